// ### bench/sst_checker.sv
`timescale 1ns/1ps
module sst_checker (
	input wire        aclk,
	input wire        aresetn,
	input wire [7:0]  awaddr,
	input wire        awvalid,
	input wire        awready,
	input wire [31:0] wdata,
	input wire [3:0]  wstrb,
	input wire        wvalid,
	input wire        wready,
	input wire [1:0]  bresp,
	input wire        bvalid,
	input wire        bready,
	input wire [7:0]  araddr,
	input wire        arvalid,
	input wire        arready,
	input wire [31:0] rdata,
	input wire [1:0]  rresp,
	input wire        rvalid,
	input wire        rready,
	input wire        shift_clock_pin,
	input wire        data_out,
	input wire        data_oe,
	input wire        sleeping,
	input wire        wake,
	input wire        vector_take
);
	default clocking dck @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	bresp_legal_a: assert property (bvalid |-> bresp == 2'b00 || bresp == 2'b10)
		else $error("write response code out of range");
	bvalid_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped early");
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	err_data_a: assert property (rvalid && rresp == 2'b10 |-> rdata == 32'h0)
		else $error("refused read carries data");
	wake_cause_a: assert property (wake |-> $past(sleeping))
		else $error("wake outside sleep");
	sleep_exit_a: assert property ($fell(sleeping) |-> wake)
		else $error("sleep left without wake");
	sleep_drive_a: assert property (sleeping && data_oe |=> data_oe)
		else $error("transmitter stopped in sleep");
	reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !data_oe && !bvalid
		&& !rvalid && !sleeping && !wake)
		else $error("outputs active after reset");
	cover property (wake);
	cover property (rvalid && rresp == 2'b10);
	cover property (sleeping && data_oe && !shift_clock_pin);
endmodule // sst_checker

bind sst_top sst_checker u_chk (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
	.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
	.rdata, .rresp, .rvalid, .rready, .shift_clock_pin, .data_out, .data_oe, .sleeping,
	.wake, .vector_take);

// ### bench/sst_master_model.sv
`timescale 1ns/1ps
module sst_master_model (
	output logic shift_clock_pin,
	input  wire  data_out,
	input  wire  data_oe
);
	initial shift_clock_pin = 1'b1;
	// Clock rests high between frames; bits are taken late in the high phase
	// since the device moves its line some of its own cycles after each fall
	task automatic frame(input int n, output logic [8:0] w);
		int k;
		w = 9'h000;
		for (k = 0; k < n; k++) begin
			shift_clock_pin = 1'b0;
			#160;
			shift_clock_pin = 1'b1;
			#150;
			w[k] = data_oe ? data_out : 1'bx;
			#10;
		end
	endtask
endmodule // sst_master_model

// ### bench/sst_top_test.sv
`timescale 1ns/1ps
`include "sst_map.vh"
module sst_top_test;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [7:0]  awaddr = 0;
	logic [7:0]  araddr = 0;
	logic [31:0] wdata = 0;
	logic [3:0]  wstrb = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	wire         awready, wready, bvalid, arready, rvalid, sck, data_out, data_oe;
	wire         sleeping, wake, vector_take;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	logic [8:0]  fr;
	int          n_fail = 0, cmp_count = 0, i;
	always #20 aclk = ~aclk;
	sst_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .shift_clock_pin(sck), .data_out, .data_oe, .sleeping, .wake,
		.vector_take);
	sst_master_model pm (.shift_clock_pin(sck), .data_out, .data_oe);
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task ok_or_quit(input logic d);
		if (d !== 1'b1) begin
			n_fail++;
			tally_and_finish;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int k;
		logic done;
		done = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (k = 0; k < 100 && !done; k++) begin
			@(posedge aclk);
			if (awready)
				awvalid <= 0;
			if (wready)
				wvalid <= 0;
			done = bvalid;
		end
		bready <= 0;
		ok_or_quit(done);
		cmp("write response", e, bresp);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int k;
		logic done;
		done = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (k = 0; k < 100 && !done; k++) begin
			@(posedge aclk);
			if (arready)
				arvalid <= 0;
			done = rvalid;
		end
		rready <= 0;
		ok_or_quit(done);
		cmp("read data", d, rdata);
		cmp("read response", e, rresp);
	endtask
	task fchk(input int n, input logic [8:0] e);
		pm.frame(n, fr);
		cmp("frame", e, fr);
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rchk(`SST_TX_CTRL_OFF, 32'h02, 2'b00);
		rchk(`SST_RCV_CTRL_OFF, 32'h00, 2'b00);
		rchk(`SST_BAUD_CTRL_OFF, 32'h40, 2'b00);
		wr(`SST_BAUD_CTRL_OFF, 32'hff, 2'b00);
		rchk(`SST_BAUD_CTRL_OFF, 32'hdb, 2'b00);
		rchk(8'h40, 32'h0, 2'b10);
		wr(8'h40, 32'h1, 2'b10);
		wr(`SST_RCV_CTRL_OFF, 32'h80, 2'b00);
		wr(`SST_INT_CTRL_OFF, 32'hc2, 2'b00);
		wr(`SST_TX_CTRL_OFF, 32'h71, 2'b00);
		rchk(`SST_INT_CTRL_OFF, 32'hc3, 2'b00);
		cmp("vector", 32'h1, vector_take);
		wr(`SST_TX_HOLD_OFF, 32'ha5, 2'b00);
		fchk(9, 9'h1a5);
		// Two words queued, then sleep: only the first may leave at once
		wr(`SST_TX_CTRL_OFF, 32'h30, 2'b00);
		wr(`SST_TX_HOLD_OFF, 32'h3c, 2'b00);
		wr(`SST_TX_HOLD_OFF, 32'hc3, 2'b00);
		wr(`SST_PWR_CTRL_OFF, 32'h1, 2'b00);
		rchk(`SST_INT_CTRL_OFF, 32'hc2, 2'b00);
		cmp("wake", 32'h0, wake);
		fchk(8, 9'h03c);
		for (i = 0; i < 50 && sleeping !== 1'b0; i++)
			@(posedge aclk);
		ok_or_quit(!sleeping);
		cmp("vector", 32'h1, vector_take);
		rchk(`SST_INT_CTRL_OFF, 32'hc3, 2'b00);
		fchk(8, 9'h0c3);
		wr(`SST_INT_CTRL_OFF, 32'h42, 2'b00);
		repeat (2) @(posedge aclk);
		cmp("vector", 32'h0, vector_take);
		tally_and_finish;
	end
endmodule // sst_top_test

// ### src/sst_map.vh
`ifndef SST_MAP_VH
`define SST_MAP_VH

// Register byte offsets (one aligned word each)
`define SST_RCV_CTRL_OFF    4'h0
`define SST_TX_HOLD_OFF     4'h4
`define SST_TX_CTRL_OFF     4'h8
`define SST_BAUD_CTRL_OFF   4'hc
`define SST_DIV_HI_OFF      5'h10
`define SST_DIV_LO_OFF      5'h14
`define SST_INT_CTRL_OFF    5'h18
`define SST_PWR_CTRL_OFF    5'h1c

// Transmit control register fields
`define SST_TXC_CLK_MASTER  7
`define SST_TXC_NINTH_ON    6
`define SST_TXC_TX_ON       5
`define SST_TXC_SYNC        4
`define SST_TXC_SEND_BREAK  3
`define SST_TXC_HIGH_RATE   2
`define SST_TXC_SHIFT_EMPTY 1
`define SST_TXC_NINTH_VAL   0

// Receive control register fields
`define SST_RXC_PORT_ON     7
`define SST_RXC_NINTH_RX    6
`define SST_RXC_SINGLE_RX   5
`define SST_RXC_CONT_RX     4
`define SST_RXC_ADDR_DET    3

// Interrupt control register fields (own word)
`define SST_INT_GLOBAL_ON   7
`define SST_INT_PERIPH_ON   6
`define SST_INT_TX_ON       1
`define SST_INT_TX_FLAG     0

// Power control: bit 0 requests sleep
`define SST_PWR_SLEEP       0

// Reset values, and the implemented-bit mask of the baud register
`define SST_TXC_RESET       8'h02
`define SST_RXC_RESET       8'h00
`define SST_BAUD_RESET      8'h40
`define SST_BAUD_IMPL       8'hdb

`endif

// ### src/sst_sync2.v
`timescale 1ns/1ps
// Two-flop synchroniser; the first stage feeds only the second.
// RST_VAL should match the idle level of the pin, so that no false edge follows reset.
module sst_sync2 #(
	parameter RST_VAL = 1'b0
) (
	aclk,
	aresetn,
	d,
	q
);
	input  wire aclk;
	input  wire aresetn;
	input  wire d;
	output reg  q;

	reg meta_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // sst_sync2

// ### src/sst_top.v
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Slave mode when synchronous mode selected and clock master select bit 7 is clear; the code also needs receive control bit 7 (port on) set
// - Shift clock comes from the external clock pin, not generated internally
// - Transfers keep running through any low-power state
// - Slave transmit matches master transmit except during sleep
// - With two words queued before sleep, first moves to shift register at once
// - Second word stays held and transmit flag stays clear while first shifts
// - After first word shifts out, second moves over, then flag sets
// - Flag rising in sleep with transmit interrupt enabled wakes the device
// - After wake, vector branch only if global interrupt enable set
// - Writing the holding register starts the transfer
// - Unimplemented register bits read as zero; receive control bits 2:0 are stored and read back as written
module sst_top (
	aclk,
	aresetn,
	awaddr,
	awvalid,
	awready,
	wdata,
	wstrb,
	wvalid,
	wready,
	bresp,
	bvalid,
	bready,
	araddr,
	arvalid,
	arready,
	rdata,
	rresp,
	rvalid,
	rready,
	shift_clock_pin,
	data_out,
	data_oe,
	sleeping,
	wake,
	vector_take
);
`include "sst_map.vh"
	input  wire        aclk;
	input  wire        aresetn;
	input  wire [7:0]  awaddr;
	input  wire        awvalid;
	output reg         awready;
	input  wire [31:0] wdata;
	input  wire [3:0]  wstrb;
	input  wire        wvalid;
	output reg         wready;
	output reg  [1:0]  bresp;
	output reg         bvalid;
	input  wire        bready;
	input  wire [7:0]  araddr;
	input  wire        arvalid;
	output reg         arready;
	output reg  [31:0] rdata;
	output reg  [1:0]  rresp;
	output reg         rvalid;
	input  wire        rready;
	input  wire        shift_clock_pin;
	output reg         data_out;
	output reg         data_oe;
	output reg         sleeping;
	output reg         wake;
	output reg         vector_take;

	reg [7:0]  tx_ctrl_r;
	reg [7:0]  rx_ctrl_r;
	reg [7:0]  baud_r;
	reg [7:0]  div_hi_r;
	reg [7:0]  div_lo_r;
	reg [7:0]  hold_r;
	reg        hold_ninth_r;
	reg        hold_full_r;
	reg [8:0]  shift_r;
	reg [3:0]  bits_left_r;
	reg        shifting_r;
	reg        tx_flag_r;
	reg        tx_ie_r;
	reg        gie_r;
	reg        peripheral_interrupt_on_r;
	reg        sck_prev_r;
	reg [7:0]  aw_addr_r;
	reg        aw_have_r;
	reg [31:0] w_data_r;
	reg [3:0]  w_strb_r;
	reg        w_have_r;

	wire       sck_s;
	wire       sck_fall;
	wire       sck_rise;
	wire       slave_mode;
	wire       ninth_on;
	wire       wr_go;
	wire       hold_wr;
	wire       load_shift;
	wire       last_bit;
	wire [7:0] wbyte;
	reg  [7:0] rd_val;
	reg        rd_ok;
	reg        wr_ok;

	// The shift clock rests high between frames
	sst_sync2 #(
		.RST_VAL (1'b1)
	) u_sck_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (shift_clock_pin),
		.q       (sck_s)
	);

	// Edges found on the synchronised external clock; nothing here is gated by
	// sleep, so shifting continues in every low-power state
	assign sck_fall   = sck_prev_r & ~sck_s;
	assign sck_rise   = ~sck_prev_r & sck_s;
	assign slave_mode = tx_ctrl_r[`SST_TXC_SYNC] & ~tx_ctrl_r[`SST_TXC_CLK_MASTER]
		& rx_ctrl_r[`SST_RXC_PORT_ON];
	assign ninth_on   = tx_ctrl_r[`SST_TXC_NINTH_ON];
	assign wr_go      = aw_have_r & w_have_r & ~bvalid;
	assign wbyte      = w_data_r[7:0];
	assign hold_wr    = wr_go & w_strb_r[0] & (aw_addr_r[7:2] == (`SST_TX_HOLD_OFF >> 2));
	// Holding word moves across only when the shifter is idle or has just sent its
	// last bit; transfer needs the transmitter on in slave mode
	assign last_bit   = shifting_r & sck_rise & (bits_left_r == 4'h1);
	assign load_shift = hold_full_r & slave_mode & tx_ctrl_r[`SST_TXC_TX_ON]
		& (~shifting_r | last_bit);

	always @* begin
		wr_ok = 1'b1;
		case (aw_addr_r[7:2])
			`SST_RCV_CTRL_OFF >> 2,
			`SST_TX_HOLD_OFF >> 2,
			`SST_TX_CTRL_OFF >> 2,
			`SST_BAUD_CTRL_OFF >> 2,
			`SST_DIV_HI_OFF >> 2,
			`SST_DIV_LO_OFF >> 2,
			`SST_INT_CTRL_OFF >> 2,
			`SST_PWR_CTRL_OFF >> 2: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always @* begin
		rd_val = 8'h00;
		rd_ok  = 1'b1;
		case (araddr[7:2])
			`SST_RCV_CTRL_OFF >> 2:  rd_val = rx_ctrl_r;
			`SST_TX_HOLD_OFF >> 2:   rd_val = hold_r;
			`SST_TX_CTRL_OFF >> 2:   rd_val = tx_ctrl_r;
			`SST_BAUD_CTRL_OFF >> 2: rd_val = baud_r & `SST_BAUD_IMPL;
			`SST_DIV_HI_OFF >> 2:    rd_val = div_hi_r;
			`SST_DIV_LO_OFF >> 2:    rd_val = div_lo_r;
			`SST_INT_CTRL_OFF >> 2:  rd_val = {gie_r, peripheral_interrupt_on_r, 4'h0, tx_ie_r, tx_flag_r};
			`SST_PWR_CTRL_OFF >> 2:  rd_val = {7'h00, sleeping};
			default: rd_ok = 1'b0;
		endcase
	end

	// AXI4-Lite write address and data: taken in either order, one write at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b0;
			wready    <= 1'b0;
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
		end else begin
			awready <= ~aw_have_r & ~awready & awvalid;
			if (awready & awvalid) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= awaddr;
			end

			wready <= ~w_have_r & ~wready & wvalid;
			if (wready & wvalid) begin
				w_have_r <= 1'b1;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end

			// Both halves are consumed together once the write is applied
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r  <= 1'b0;
			end
		end
	end

	// Write response stands until the master takes it
	always @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= 2'b00;
		end else begin
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp  <= wr_ok ? 2'b00 : 2'b10;
			end else if (bvalid & bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read channel: address is held by the master until arready, so the
	// combinational decode is still valid at the capture edge
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= 2'b00;
		end else begin
			arready <= ~arready & ~rvalid & arvalid;
			if (arready & arvalid) begin
				rvalid <= 1'b1;
				rdata  <= {24'h000000, rd_val};
				rresp  <= rd_ok ? 2'b00 : 2'b10;
			end else if (rvalid & rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// Control registers; the shift-empty status bit is owned by the shifter
	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_ctrl_r <= `SST_TXC_RESET;
			rx_ctrl_r <= `SST_RXC_RESET;
			baud_r    <= `SST_BAUD_RESET;
			div_hi_r  <= 8'h00;
			div_lo_r  <= 8'h00;
			tx_ie_r   <= 1'b0;
			gie_r     <= 1'b0;
			peripheral_interrupt_on_r    <= 1'b0;
			sleeping  <= 1'b0;
		end else begin
			tx_ctrl_r[`SST_TXC_SHIFT_EMPTY] <= ~shifting_r & ~load_shift;
			if (wr_go & w_strb_r[0]) begin
				case (aw_addr_r[7:2])
					`SST_RCV_CTRL_OFF >> 2: rx_ctrl_r <= wbyte;
					`SST_TX_CTRL_OFF >> 2: begin
						tx_ctrl_r[7:2] <= wbyte[7:2];
						tx_ctrl_r[0]   <= wbyte[0];
					end
					`SST_BAUD_CTRL_OFF >> 2: baud_r <= wbyte & `SST_BAUD_IMPL;
					`SST_DIV_HI_OFF >> 2: div_hi_r <= wbyte;
					`SST_DIV_LO_OFF >> 2: div_lo_r <= wbyte;
					`SST_INT_CTRL_OFF >> 2: begin
						gie_r   <= wbyte[`SST_INT_GLOBAL_ON];
						peripheral_interrupt_on_r  <= wbyte[`SST_INT_PERIPH_ON];
						tx_ie_r <= wbyte[`SST_INT_TX_ON];
					end
					`SST_PWR_CTRL_OFF >> 2: sleeping <= wbyte[`SST_PWR_SLEEP];
					default: ;
				endcase
			end
			// Wake clears sleep; it wins over a same-cycle sleep request
			if (sleeping & tx_flag_r & tx_ie_r)
				sleeping <= 1'b0;
		end
	end

	// Holding register, shifter and transmit flag
	always @(posedge aclk) begin
		if (!aresetn) begin
			hold_r       <= 8'h00;
			hold_ninth_r <= 1'b0;
			hold_full_r  <= 1'b0;
			shift_r      <= 9'h000;
			bits_left_r  <= 4'h0;
			shifting_r   <= 1'b0;
			tx_flag_r    <= 1'b0;
			sck_prev_r   <= 1'b1;
			data_out     <= 1'b0;
			data_oe      <= 1'b0;
		end else begin
			sck_prev_r <= sck_s;
			data_oe    <= slave_mode & tx_ctrl_r[`SST_TXC_TX_ON];
			if (shifting_r & sck_rise) begin
				shift_r     <= {1'b0, shift_r[8:1]};
				bits_left_r <= bits_left_r - 4'h1;
				if (bits_left_r == 4'h1)
					shifting_r <= 1'b0;
			end
			if (shifting_r & sck_fall)
				data_out <= shift_r[0];
			if (load_shift) begin
				shift_r     <= {hold_ninth_r, hold_r};
				bits_left_r <= ninth_on ? 4'h9 : 4'h8;
				shifting_r  <= 1'b1;
				hold_full_r <= 1'b0;
				// Only an idle line gets the first bit at once; after a back-to-back
				// load the last bit of the old word must stand until the next fall
				if (~shifting_r)
					data_out <= hold_r[0];
			end

			// Flag: empty holding register; load wins over a same-cycle empty
			if (hold_wr) begin
				hold_r       <= wbyte;
				hold_ninth_r <= tx_ctrl_r[`SST_TXC_NINTH_VAL];
				hold_full_r  <= 1'b1;
				tx_flag_r    <= 1'b0;
			end else if (load_shift) begin
				tx_flag_r <= 1'b1;
			end else if (~hold_full_r & tx_ctrl_r[`SST_TXC_TX_ON]) begin
				tx_flag_r <= 1'b1;
			end
		end
	end

	// Wake pulse and vector decision
	always @(posedge aclk) begin
		if (!aresetn) begin
			wake        <= 1'b0;
			vector_take <= 1'b0;
		end else begin
			wake        <= sleeping & tx_flag_r & tx_ie_r;
			vector_take <= tx_flag_r & tx_ie_r & gie_r & peripheral_interrupt_on_r;
		end
	end
endmodule // sst_top
